// ### core/aits_pkg.sv
// Contract
// - internal conversion clock waits a programmable delay after sample, default three ticks
// - sample and conversion pulses are ignored until the start trigger is seen
// - after a sample pulse, further sample pulses wait until all conversions arrive
// - conversion pulses are ignored while no sample is open
// - after the last conversion, more conversions wait for the next sample
// - single-clock mode: each edge of one signal makes one conversion
// - conversion timebase is sample timebase or 20 MHz, then divided
// - hold-done pulse of chosen polarity follows each conversion, routable out
// - start by trigger or command; stop by count, reference, or command
// - digital start trigger has selectable source and edge
// - analog comparison start begins on its first rising edge
// - start trigger routed out is an active-high pulse
// - posttrigger count equals buffer size minus pretrigger count
// - reference trigger armed only after pretrigger samples are captured
// - while waiting for reference, buffer writes wrap over oldest sample
// - after reference, store posttrigger samples then end acquisition
// - digital reference trigger has selectable source and edge
// - analog comparison reference stops on its first rising edge
// - internal sample clock halts while pause is at its active level
// - pause is level-only and routes out only on sync bus lines
// - analog comparison pause acts on its level, polarity selectable
// - function terminals leave reset as inputs, drive only once enabled
// - each sample makes one conversion per channel of the scan list
// - conversion divider starts on sample, counts down to one, pulses, reloads
package aits_pkg;
  localparam int          NLINE     = 27;
  localparam int          NSYNC     = 26;
  localparam logic [4:0]  SRC_ACMP  = 5'h19;
  localparam int          CLK_MHZ   = 125;
  localparam int          TB20_MHZ  = 20;
  localparam logic [7:0]  TB_STEP   = 8'(TB20_MHZ);
  localparam logic [7:0]  TB_MOD    = 8'(CLK_MHZ);
  localparam logic [7:0]  A_CTRL    = 8'h00;
  localparam logic [7:0]  A_TRIG    = 8'h04;
  localparam logic [7:0]  A_CLK     = 8'h08;
  localparam logic [7:0]  A_SDIV    = 8'h0C;
  localparam logic [7:0]  A_CDIV    = 8'h10;
  localparam logic [7:0]  A_CDLY    = 8'h14;
  localparam logic [7:0]  A_NCH     = 8'h18;
  localparam logic [7:0]  A_BUFSZ   = 8'h1C;
  localparam logic [7:0]  A_PRE     = 8'h20;
  localparam logic [7:0]  A_ROUTE   = 8'h24;
  localparam logic [7:0]  A_STAT    = 8'h28;
  localparam logic [7:0]  A_SCNT    = 8'h2C;
  localparam int          C_GO      = 0;
  localparam int          C_STOP    = 1;
  localparam int          C_FINITE  = 2;
  localparam int          C_REFEN   = 3;
  localparam int          C_USETRIG = 4;
  localparam int          C_SEXT    = 5;
  localparam int          C_CEXT    = 6;
  localparam int          C_SINGLE  = 7;
  localparam int          C_CTB20   = 8;
  localparam int          C_HPOL    = 9;
  localparam int          C_STB20   = 10;
  localparam int          C_PAUSEEN = 11;
  localparam logic [15:0] CDLY_RST  = 16'h0003;
  localparam logic [15:0] DIV_RST   = 16'h0001;
  localparam logic [7:0]  NCH_RST   = 8'h01;
  localparam logic [1:0]  SIG_START = 2'h0;
  localparam logic [1:0]  SIG_HOLD  = 2'h1;
  localparam logic [1:0]  SIG_REF   = 2'h2;
  localparam logic [1:0]  SIG_PAUSE = 2'h3;

  typedef struct packed {
    logic       fall;
    logic [4:0] src;
  } aits_trig_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARM  = 4'h2,
    ST_RUN  = 4'h4,
    ST_POST = 4'h8
  } aits_state_type;

  function automatic logic aits_pick(input logic [NLINE-1:0] v, input logic [4:0] s);
    return (32'(s) < NLINE) ? v[s] : 1'b0;
  endfunction

  function automatic aits_trig_type aits_cfg(input logic [5:0] f);
    return aits_trig_type'(f);
  endfunction
endpackage

// ### core/aits_sync.sv
`timescale 1ns/1ps
module aits_sync
  import aits_pkg::*;
#(
  parameter int W = NSYNC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ### core/aits_edge_sel.sv
`timescale 1ns/1ps
module aits_edge_sel
  import aits_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [NLINE-1:0] lines,
  input  wire aits_trig_type    cfg,
  output logic                  lvl,
  output logic                  edge_p
);
  logic prev_r;
  logic inv;

  // analog comparison always acts on its rising edge
  assign inv    = cfg.fall & (cfg.src != SRC_ACMP);
  assign lvl    = aits_pick(lines, cfg.src) ^ inv;
  assign edge_p = lvl & ~prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= lvl;
    end
  end
endmodule

// ### core/aits_sequencer.sv
`timescale 1ns/1ps
module aits_sequencer
  import aits_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] function_terminal_in,
  input  wire logic [7:0]  sync_bus_line_in,
  input  wire logic        chassis_star_trigger_in,
  input  wire logic        analog_compare_in,
  input  wire logic        counter_out_in,
  output logic      [15:0] function_terminal_out,
  output logic      [15:0] function_terminal_oe,
  output logic      [7:0]  sync_bus_line_out,
  output logic      [7:0]  sync_bus_line_oe,
  output logic             per_channel_conversion_clock,
  output logic             conversion_hold_done_pulse,
  output logic             buf_wr_en,
  output logic      [23:0] buf_wr_addr,
  output logic             acq_active
);
  logic [11:0]     ctrl_r;
  logic [23:0]     trig_r;
  logic [23:0]     clk_r;
  logic [15:0]     sdiv_r;
  logic [15:0]     cdiv_r;
  logic [15:0]     cdly_r;
  logic [7:0]      nch_r;
  logic [23:0]     bufsz_r;
  logic [23:0]     pre_r;
  logic [27:0]     route_r;
  aits_state_type  state_r;
  logic [25:0]     synced;
  logic [NLINE-1:0] lines;
  logic            wr_en;
  logic            go_cmd;
  logic            stop_cmd;
  logic            start_lvl, start_edge, ref_lvl, ref_edge, pause_lvl, pause_edge;
  logic            stb_lvl, stb_edge, sx_lvl, sx_edge, cx_lvl, cx_edge;
  logic [7:0]      tb_acc_r;
  logic            tb20_tick_r;
  logic            samp_tb_tick, conv_tb_tick;
  logic [15:0]     scnt_div_r;
  logic            int_samp_tick;
  logic            samp_tick;
  logic            paused;
  logic            running;
  logic            single;
  logic            in_sample_r;
  logic            accept;
  logic [15:0]     ccnt_r;
  logic            int_emit;
  logic            conv_evt;
  logic [7:0]      chan_r;
  logic            last_chan;
  logic            sample_done;
  logic [23:0]     samp_cnt_r;
  logic [23:0]     post_left_r;
  logic            armed;
  logic            ref_hit;
  logic            start_pulse_r;
  logic            ref_pulse_r;
  logic            sig_ft, sig_sb;

  assign wr_en    = psel & penable & pready & pwrite;
  assign go_cmd   = wr_en & (paddr == A_CTRL) & pwdata[C_GO];
  assign stop_cmd = wr_en & (paddr == A_CTRL) & pwdata[C_STOP];
  assign single   = ctrl_r[C_SINGLE];
  assign running  = (state_r == ST_RUN) | (state_r == ST_POST);

  aits_sync #(.W(NSYNC)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({analog_compare_in, chassis_star_trigger_in, sync_bus_line_in,
                function_terminal_in}),
    .q       (synced)
  );
  // counter output already runs on pclk, so it skips the synchroniser
  assign lines = {counter_out_in, synced};

  aits_edge_sel u_start (.pclk(pclk), .presetn(presetn), .lines(lines),
    .cfg(aits_cfg(trig_r[5:0])), .lvl(start_lvl), .edge_p(start_edge));
  aits_edge_sel u_ref (.pclk(pclk), .presetn(presetn), .lines(lines),
    .cfg(aits_cfg(trig_r[13:8])), .lvl(ref_lvl), .edge_p(ref_edge));
  aits_edge_sel u_pause (.pclk(pclk), .presetn(presetn), .lines(lines),
    .cfg(aits_cfg(trig_r[21:16])), .lvl(pause_lvl), .edge_p(pause_edge));
  aits_edge_sel u_stb (.pclk(pclk), .presetn(presetn), .lines(lines),
    .cfg(aits_cfg(clk_r[5:0])), .lvl(stb_lvl), .edge_p(stb_edge));
  aits_edge_sel u_sx (.pclk(pclk), .presetn(presetn), .lines(lines),
    .cfg(aits_cfg(clk_r[13:8])), .lvl(sx_lvl), .edge_p(sx_edge));
  aits_edge_sel u_cx (.pclk(pclk), .presetn(presetn), .lines(lines),
    .cfg(aits_cfg(clk_r[21:16])), .lvl(cx_lvl), .edge_p(cx_edge));

  // apb: one wait-free access after the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > A_SCNT | paddr[1:0] != 2'h0);
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          A_CTRL:  prdata <= {20'h0, ctrl_r[11:2], 2'h0};
          A_TRIG:  prdata <= {8'h0, trig_r};
          A_CLK:   prdata <= {8'h0, clk_r};
          A_SDIV:  prdata <= {16'h0, sdiv_r};
          A_CDIV:  prdata <= {16'h0, cdiv_r};
          A_CDLY:  prdata <= {16'h0, cdly_r};
          A_NCH:   prdata <= {24'h0, nch_r};
          A_BUFSZ: prdata <= {8'h0, bufsz_r};
          A_PRE:   prdata <= {8'h0, pre_r};
          A_ROUTE: prdata <= {4'h0, route_r};
          A_STAT:  prdata <= {16'h0, chan_r, 1'b0, paused, armed, in_sample_r, state_r};
          A_SCNT:  prdata <= {8'h0, samp_cnt_r};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= 12'h0;
      trig_r  <= 24'h0;
      clk_r   <= 24'h0;
      sdiv_r  <= DIV_RST;
      cdiv_r  <= DIV_RST;
      cdly_r  <= CDLY_RST;
      nch_r   <= NCH_RST;
      bufsz_r <= 24'h0;
      pre_r   <= 24'h0;
      route_r <= 28'h0;
    end else if (wr_en) begin
      case (paddr)
        A_CTRL:  ctrl_r  <= {pwdata[11:2], 2'h0};
        A_TRIG:  trig_r  <= pwdata[23:0];
        A_CLK:   clk_r   <= pwdata[23:0];
        A_SDIV:  sdiv_r  <= pwdata[15:0];
        A_CDIV:  cdiv_r  <= pwdata[15:0];
        A_CDLY:  cdly_r  <= pwdata[15:0];
        A_NCH:   nch_r   <= pwdata[7:0];
        A_BUFSZ: bufsz_r <= pwdata[23:0];
        A_PRE:   pre_r   <= pwdata[23:0];
        A_ROUTE: route_r <= pwdata[27:0];
        default: ctrl_r  <= ctrl_r;
      endcase
    end
  end

  // 20 MHz tick from the 125 MHz clock by a fractional accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_acc_r    <= 8'h0;
      tb20_tick_r <= 1'b0;
    end else if (tb_acc_r + TB_STEP >= TB_MOD) begin
      tb_acc_r    <= tb_acc_r + TB_STEP - TB_MOD;
      tb20_tick_r <= 1'b1;
    end else begin
      tb_acc_r    <= tb_acc_r + TB_STEP;
      tb20_tick_r <= 1'b0;
    end
  end

  assign samp_tb_tick = ctrl_r[C_STB20] ? tb20_tick_r : stb_edge;
  assign conv_tb_tick = ctrl_r[C_CTB20] ? tb20_tick_r : samp_tb_tick;
  // pause_edge is unused on purpose: pause acts on level only
  assign paused = ctrl_r[C_PAUSEEN] &
                  (pause_lvl ^ (trig_r[21] & (trig_r[20:16] == SRC_ACMP)));

  // internal sample clock divider, frozen while paused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt_div_r <= DIV_RST;
    end else if (!running) begin
      scnt_div_r <= sdiv_r;
    end else if (samp_tb_tick & ~paused) begin
      scnt_div_r <= (scnt_div_r <= 16'h1) ? sdiv_r : scnt_div_r - 16'h1;
    end
  end
  assign int_samp_tick = running & samp_tb_tick & ~paused & (scnt_div_r <= 16'h1);
  assign samp_tick     = ctrl_r[C_SEXT] ? (sx_edge & ~paused) : int_samp_tick;

  // a sample opens only when none is open and the acquisition runs
  assign accept = running & ~single & ~in_sample_r & samp_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccnt_r <= CDLY_RST;
    end else if (accept) begin
      ccnt_r <= cdly_r;
    end else if (in_sample_r & conv_tb_tick) begin
      ccnt_r <= (ccnt_r <= 16'h1) ? cdiv_r : ccnt_r - 16'h1;
    end
  end
  assign int_emit = in_sample_r & conv_tb_tick & (ccnt_r <= 16'h1);

  // single-clock mode: every sample-clock edge is a conversion
  assign conv_evt = running & (single ? sx_edge :
                    in_sample_r & (ctrl_r[C_CEXT] ? cx_edge : int_emit));
  assign last_chan   = (9'(chan_r) + 9'h1) >= 9'(nch_r);
  assign sample_done = conv_evt & last_chan;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sample_r <= 1'b0;
      chan_r      <= 8'h0;
    end else if (!running) begin
      in_sample_r <= 1'b0;
      chan_r      <= 8'h0;
    end else if (accept) begin
      in_sample_r <= 1'b1;
    end else if (conv_evt) begin
      in_sample_r <= ~last_chan;
      chan_r      <= last_chan ? 8'h0 : chan_r + 8'h1;
    end
  end

  assign armed   = ctrl_r[C_REFEN] & ctrl_r[C_FINITE] & (samp_cnt_r >= pre_r);
  assign ref_hit = (state_r == ST_RUN) & armed & ref_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else if (stop_cmd) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go_cmd) begin
            state_r <= pwdata[C_USETRIG] ? ST_ARM : ST_RUN;
          end
        end
        ST_ARM: begin
          if (start_edge) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (ref_hit) begin
            state_r <= ST_POST;
          end else if (ctrl_r[C_FINITE] & ~ctrl_r[C_REFEN] & sample_done &
                       samp_cnt_r + 24'h1 >= bufsz_r) begin
            state_r <= ST_IDLE;
          end
        end
        ST_POST: begin
          if (post_left_r == 24'h0 | (sample_done & post_left_r == 24'h1)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_cnt_r  <= 24'h0;
      post_left_r <= 24'h0;
    end else if (state_r == ST_IDLE) begin
      samp_cnt_r  <= 24'h0;
      post_left_r <= 24'h0;
    end else begin
      if (sample_done & samp_cnt_r != 24'hFFFFFF) begin
        samp_cnt_r <= samp_cnt_r + 24'h1;
      end
      if (ref_hit) begin
        post_left_r <= bufsz_r - pre_r;
      end else if (state_r == ST_POST & sample_done & post_left_r != 24'h0) begin
        post_left_r <= post_left_r - 24'h1;
      end
    end
  end

  // buffer address wraps so the oldest sample is overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wr_en   <= 1'b0;
      buf_wr_addr <= 24'h0;
    end else begin
      buf_wr_en <= sample_done;
      if (state_r == ST_IDLE) begin
        buf_wr_addr <= 24'h0;
      end else if (buf_wr_en) begin
        buf_wr_addr <= (buf_wr_addr + 24'h1 >= bufsz_r) ? 24'h0 : buf_wr_addr + 24'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_channel_conversion_clock <= 1'b0;
      conversion_hold_done_pulse   <= 1'b0;
      acq_active                   <= 1'b0;
      start_pulse_r                <= 1'b0;
      ref_pulse_r                  <= 1'b0;
    end else begin
      per_channel_conversion_clock <= conv_evt;
      conversion_hold_done_pulse   <= per_channel_conversion_clock ^ ctrl_r[C_HPOL];
      acq_active                   <= running;
      start_pulse_r                <= (state_r == ST_ARM & start_edge) |
                                      (state_r == ST_IDLE & go_cmd & ~pwdata[C_USETRIG]);
      ref_pulse_r                  <= ref_hit;
    end
  end

  // pause has no path onto the function terminals
  always_comb begin
    case (route_r[25:24])
      SIG_START: sig_ft = start_pulse_r;
      SIG_HOLD:  sig_ft = conversion_hold_done_pulse;
      SIG_REF:   sig_ft = ref_pulse_r;
      default:   sig_ft = 1'b0;
    endcase
    case (route_r[27:26])
      SIG_START: sig_sb = start_pulse_r;
      SIG_HOLD:  sig_sb = conversion_hold_done_pulse;
      SIG_REF:   sig_sb = ref_pulse_r;
      default:   sig_sb = paused;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_terminal_out <= 16'h0;
      function_terminal_oe  <= 16'h0;
      sync_bus_line_out     <= 8'h0;
      sync_bus_line_oe      <= 8'h0;
    end else begin
      function_terminal_out <= {16{sig_ft}} & route_r[15:0];
      function_terminal_oe  <= route_r[15:0];
      sync_bus_line_out     <= {8{sig_sb}} & route_r[23:16];
      sync_bus_line_oe      <= route_r[23:16];
    end
  end

  conv_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
    per_channel_conversion_clock |-> $past(running))
    else $error("conversion outside a running acquisition");
  conv_in_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_evt & ~single) |-> in_sample_r)
    else $error("conversion without an open sample");
  no_reaccept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_sample_r & ~(conv_evt & last_chan)) |=> in_sample_r | ~running)
    else $error("sample closed before its conversions");
  first_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (accept & ~ctrl_r[C_CEXT] & cdly_r > 16'h1) |=> ~int_emit)
    else $error("first conversion came before the delay");
  hold_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (per_channel_conversion_clock & $stable(ctrl_r)) |=>
    conversion_hold_done_pulse == ~ctrl_r[C_HPOL])
    else $error("hold-done pulse missing after conversion");
  start_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_pulse_r |=> ~start_pulse_r)
    else $error("start output longer than one cycle");
  early_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_RUN & ref_edge & ~armed & ~stop_cmd & ~sample_done) |=>
    state_r == ST_RUN)
    else $error("reference accepted before pretrigger count");
  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (running & paused & ~ctrl_r[C_SEXT] & $past(running)) |=> $stable(scnt_div_r))
    else $error("sample divider moved while paused");
  wrap_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (buf_wr_en & state_r != ST_IDLE & buf_wr_addr + 24'h1 >= bufsz_r) |=>
    buf_wr_addr == 24'h0)
    else $error("buffer address did not wrap");
  post_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_POST & post_left_r == 24'h0 & ~stop_cmd) |=> state_r == ST_IDLE)
    else $error("acquisition ran past posttrigger count");

  accept_c: cover property (@(posedge pclk) disable iff (!presetn) accept);
  post_c: cover property (@(posedge pclk) disable iff (!presetn) state_r == ST_POST);
  single_c: cover property (@(posedge pclk) disable iff (!presetn) single & conv_evt);
  pause_c: cover property (@(posedge pclk) disable iff (!presetn) running & paused);
endmodule

// ### verif/aits_src_model.sv
`timescale 1ns/1ps
module aits_src_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        per_channel_conversion_clock,
  input  wire logic        conversion_hold_done_pulse,
  input  wire logic        buf_wr_en,
  output logic      [15:0] ft_drive
);
  int n_conv;
  int n_hold;
  int n_wr;
  initial ft_drive = 16'h0000;
  // held two cycles so the synchroniser never misses the edge
  task automatic pulse(input int idx);
    @(posedge pclk);
    ft_drive[idx] <= 1'b1;
    repeat (2) @(posedge pclk);
    ft_drive[idx] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_conv = 0;
      n_hold = 0;
      n_wr = 0;
    end else begin
      if (per_channel_conversion_clock === 1'b1) n_conv++;
      if (conversion_hold_done_pulse === 1'b1) n_hold++;
      if (buf_wr_en === 1'b1) n_wr++;
    end
  end
endmodule

// ### verif/ai_acquisition_timing_sequencer_test.sv
`timescale 1ns/1ps
module ai_acquisition_timing_sequencer_test;
  import aits_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] ft_in;
  logic [15:0] ft_oe;
  logic [15:0] ft_out;
  logic [7:0]  sb_in = 8'h00;
  logic [7:0]  sb_out;
  logic [7:0]  sb_oe;
  logic [23:0] wr_addr;
  logic        active;
  logic        star_in = 1'b0;
  logic        acmp_in = 1'b0;
  logic        cnt_in = 1'b0;
  int          n_ft = 0;
  int          n_sb = 0;
  logic        conv;
  logic        hold;
  logic        wr_en;
  logic [31:0] r;
  logic        e;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [7:0]  row_a [6] = '{A_CTRL, A_SDIV, A_CDIV, A_CDLY, A_NCH, A_STAT};
  logic [31:0] row_d [6] = '{32'h0, 32'h1, 32'h1, 32'h3, 32'h1, 32'h1};
  always #4 pclk = ~pclk;
  aits_sequencer dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .function_terminal_in(ft_in), .sync_bus_line_in(sb_in), .chassis_star_trigger_in(star_in),
    .analog_compare_in(acmp_in), .counter_out_in(cnt_in), .function_terminal_out(ft_out),
    .function_terminal_oe(ft_oe), .sync_bus_line_out(sb_out), .sync_bus_line_oe(sb_oe),
    .per_channel_conversion_clock(conv), .conversion_hold_done_pulse(hold),
    .buf_wr_en(wr_en), .buf_wr_addr(wr_addr), .acq_active(active)
  );
  aits_src_model src_u (
    .pclk(pclk), .presetn(presetn), .per_channel_conversion_clock(conv),
    .conversion_hold_done_pulse(hold), .buf_wr_en(wr_en), .ft_drive(ft_in)
  );
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following setup never re-drives psel in this step
    @(posedge pclk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic counts(input int c, input int w);
    check(32'(src_u.n_conv), 32'(c));
    check(32'(src_u.n_hold), 32'(c));
    check(32'(src_u.n_wr), 32'(w));
  endtask
  // counter line runs on pclk, so one cycle high is one edge
  task automatic samp;
    cnt_in <= 1'b1;
    @(posedge pclk);
    cnt_in <= 1'b0;
    repeat (40) @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // run is about 500 cycles, so this ceiling only trips on a hang
  always @(posedge pclk) begin
    cyc++;
    if (ft_out[3] === 1'b1) n_ft++;
    if (sb_out[0] === 1'b1) n_sb++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(ft_oe), 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(row_a[i], 1'b0, 32'h0);
      check(r, row_d[i]);
    end
    apb(8'h30, 1'b0, 32'h0);
    check(32'(e), 32'h1);
    apb(A_ROUTE, 1'b1, 32'h01000008);
    @(posedge pclk);
    check(32'(ft_oe), 32'h8);
    apb(A_CLK, 1'b1, 32'h00010000);
    apb(A_NCH, 1'b1, 32'h2);
    src_u.pulse(0);
    src_u.pulse(1);
    counts(0, 0);
    apb(A_CTRL, 1'b1, 32'h61);
    src_u.pulse(1);
    counts(0, 0);
    src_u.pulse(0);
    src_u.pulse(0);
    src_u.pulse(1);
    src_u.pulse(1);
    counts(2, 1);
    src_u.pulse(1);
    counts(2, 1);
    check(32'(n_ft), 32'h2);
    check(32'(active), 32'h1);
    apb(A_SCNT, 1'b0, 32'h0);
    check(r, 32'h1);
    apb(A_CTRL, 1'b1, 32'h2);
    repeat (3) @(posedge pclk);
    apb(A_STAT, 1'b0, 32'h0);
    check({28'h0, r[3:0]}, 32'h1);
    check(32'(active), 32'h0);
    apb(A_CTRL, 1'b1, 32'hA1);
    src_u.pulse(0);
    src_u.pulse(0);
    counts(4, 2);
    check(32'(n_ft), 32'h4);
    apb(A_CTRL, 1'b1, 32'h2);
    apb(A_TRIG, 1'b1, 32'h00183932);
    apb(A_CLK, 1'b1, 32'h00001A00);
    apb(A_NCH, 1'b1, 32'h1);
    apb(A_BUFSZ, 1'b1, 32'h3);
    apb(A_PRE, 1'b1, 32'h2);
    apb(A_ROUTE, 1'b1, 32'h01010008);
    sb_in <= 8'h04;
    apb(A_CTRL, 1'b1, 32'h93D);
    samp();
    counts(4, 2);
    sb_in <= 8'h00;
    repeat (8) @(posedge pclk);
    check(32'(n_sb), 32'h1);
    check(32'(sb_oe), 32'h1);
    star_in <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(A_STAT, 1'b0, 32'h0);
    check(r, 32'h44);
    samp();
    counts(4, 2);
    star_in <= 1'b0;
    repeat (4) @(posedge pclk);
    samp();
    counts(5, 3);
    acmp_in <= 1'b1;
    repeat (6) @(posedge pclk);
    acmp_in <= 1'b0;
    apb(A_STAT, 1'b0, 32'h0);
    check(r, 32'h4);
    samp();
    check(32'(wr_addr), 32'h2);
    samp();
    check(32'(wr_addr), 32'h0);
    acmp_in <= 1'b1;
    repeat (6) @(posedge pclk);
    acmp_in <= 1'b0;
    apb(A_STAT, 1'b0, 32'h0);
    check(r, 32'h28);
    apb(A_SCNT, 1'b0, 32'h0);
    check(r, 32'h3);
    samp();
    apb(A_STAT, 1'b0, 32'h0);
    check(r, 32'h1);
    counts(8, 6);
    check(32'(n_ft), 32'h8);
    apb(A_TRIG, 1'b1, 32'h00390000);
    repeat (4) @(posedge pclk);
    apb(A_STAT, 1'b0, 32'h0);
    check(r, 32'h41);
    acmp_in <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(A_STAT, 1'b0, 32'h0);
    check(r, 32'h1);
    apb(A_CTRL, 1'b1, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({ft_oe, sb_oe, 7'h0, active}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(A_STAT, 1'b0, 32'h0);
    check(r, 32'h1);
    complete_run();
  end
endmodule
